// *** verilog/dsr_regs.sv ***
// status and error register bank of the disk controller, apb slave
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "dsr_defs.svh"
module dsr_regs
	import dsr_pkg::*;
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// drive levels from the pins
	input wire logic DRIVE_BUSY_IN,
	input wire logic DRIVE_READY_IN,
	input wire logic WRITE_FAULT_IN,
	input wire logic SEEK_DONE_IN,
	input wire logic TRANSFER_REQUEST_IN,
	input wire logic INDEX_PULSE_IN,
	// command engine events, same clock
	input wire logic CMD_DONE_IN,
	input wire logic FIXED_DATA_EV_IN,
	input wire logic UNFIXABLE_DATA_EV_IN,
	input wire logic SECTOR_ID_MISSING_EV_IN,
	input wire logic COMMAND_REJECTED_EV_IN,
	input wire logic HOME_TRACK_MISSING_EV_IN,
	input wire logic BAD_BLOCK_EV_IN,
	// register mirrors
	output logic [7:0] STATUS_OUT,
	output logic [7:0] ERROR_OUT
);
	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	logic [7:0] pins_raw;
	logic [7:0] pins;

	assign pins_raw = {2'b00, DRIVE_BUSY_IN, DRIVE_READY_IN, WRITE_FAULT_IN,
		SEEK_DONE_IN, TRANSFER_REQUEST_IN, INDEX_PULSE_IN};

	dsr_sync u_sync (
		.CLK_IN(CLK_IN),
		.RST_N_IN(RST_N_IN),
		.d_in(pins_raw),
		.q_out(pins)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	dsr_state_type r;
	dsr_state_type next_r;
	logic [7:0] status_byte;
	logic [7:0] error_byte;
	logic setup;
	logic wr;
	logic rd;
	logic cmd_error_any;

	// ----------------------------------------
	// byte assembly
	// ----------------------------------------
	always_comb begin
		status_byte = `DSR_RESET_BYTE;
		status_byte[`DSR_ST_BUSY] = r.status.busy;
		status_byte[`DSR_ST_READY] = r.status.ready;
		status_byte[`DSR_ST_WFAULT] = r.status.write_fault;
		status_byte[`DSR_ST_SEEK] = r.status.seek_done;
		status_byte[`DSR_ST_XFER] = r.status.transfer_request;
		status_byte[`DSR_ST_FIXED] = r.status.fixed_data;
		status_byte[`DSR_ST_INDEX] = r.status.index_pulse;
		status_byte[`DSR_ST_ERR] = r.status.command_error;
		// unused bits stay zero
		error_byte = `DSR_RESET_BYTE;
		error_byte[`DSR_ER_BADBLK] = r.error.bad_block;
		error_byte[`DSR_ER_UNFIX] = r.error.unfixable_data;
		error_byte[`DSR_ER_IDMISS] = r.error.sector_id_missing;
		error_byte[`DSR_ER_REJECT] = r.error.command_rejected;
		error_byte[`DSR_ER_HOME] = r.error.home_track_missing;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		setup = PSEL_IN && !PENABLE_IN;
		wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
		rd = setup && !PWRITE_IN;
		cmd_error_any = UNFIXABLE_DATA_EV_IN || SECTOR_ID_MISSING_EV_IN
			|| COMMAND_REJECTED_EV_IN || HOME_TRACK_MISSING_EV_IN
			|| BAD_BLOCK_EV_IN;

		// live drive levels
		next_r.status.busy = pins[5];
		next_r.status.ready = pins[4];
		next_r.status.write_fault = pins[3];
		next_r.status.seek_done = pins[2];
		next_r.status.transfer_request = pins[1];
		next_r.status.index_pulse = pins[0];

		// software clear from the command word; events below win
		if (wr && PADDR_IN == `DSR_CMD_OFS && PWDATA_IN[`DSR_CMD_CLEAR]) begin
			next_r.status.fixed_data = 1'b0;
			next_r.status.command_error = 1'b0;
			next_r.error = '0;
		end

		// a new command end restarts the error picture
		if (CMD_DONE_IN) begin
			next_r.status.fixed_data = FIXED_DATA_EV_IN;
			next_r.status.command_error = cmd_error_any;
			next_r.error.unfixable_data = UNFIXABLE_DATA_EV_IN;
			next_r.error.sector_id_missing = SECTOR_ID_MISSING_EV_IN;
			next_r.error.command_rejected = COMMAND_REJECTED_EV_IN;
			next_r.error.home_track_missing = HOME_TRACK_MISSING_EV_IN;
			next_r.error.bad_block = BAD_BLOCK_EV_IN;
		end

		// apb: answer in the access cycle, data fetched at setup
		next_r.apb.pready = setup;
		next_r.apb.pslverr = 1'b0;
		if (setup) begin
			next_r.apb.prdata = `DSR_RESET_WORD;
		end
		if (setup && PADDR_IN == `DSR_STATUS_OFS) begin
			next_r.apb.prdata = {24'h000000, status_byte};
		end else if (setup && PADDR_IN == `DSR_ERROR_OFS) begin
			next_r.apb.prdata = {24'h000000, error_byte};
		end else if (setup && PADDR_IN == `DSR_CMD_OFS) begin
			next_r.apb.prdata = `DSR_RESET_WORD;
		end else if (setup) begin
			next_r.apb.pslverr = 1'b1;
		end
		if (!rd && setup) begin
			next_r.apb.prdata = `DSR_RESET_WORD;
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign PRDATA_OUT = r.apb.prdata;
	assign PREADY_OUT = r.apb.pready;
	assign PSLVERR_OUT = r.apb.pslverr;
	// mirrors are combinational bytes of flops; bits are straight copies
	assign STATUS_OUT = status_byte;
	assign ERROR_OUT = error_byte;
endmodule // dsr_regs

// *** verilog/dsr_defs.svh ***
// constants for the disk controller status and error register bank
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DSR_STATUS_OFS 12'h000
`define DSR_ERROR_OFS 12'h004
`define DSR_CMD_OFS 12'h008

// ----------------------------------------
// status byte fields
// ----------------------------------------
`define DSR_ST_BUSY 7
`define DSR_ST_READY 6
`define DSR_ST_WFAULT 5
`define DSR_ST_SEEK 4
`define DSR_ST_XFER 3
`define DSR_ST_FIXED 2
`define DSR_ST_INDEX 1
`define DSR_ST_ERR 0

// ----------------------------------------
// error byte fields
// ----------------------------------------
`define DSR_ER_BADBLK 7
`define DSR_ER_UNFIX 6
`define DSR_ER_IDMISS 4
`define DSR_ER_REJECT 2
`define DSR_ER_HOME 1
`define DSR_ER_USED_MASK 8'hD6

// ----------------------------------------
// command register fields and reset values
// ----------------------------------------
`define DSR_CMD_CLEAR 0
`define DSR_RESET_BYTE 8'h00
`define DSR_RESET_WORD 32'h0000_0000

`endif

// *** verilog/dsr_pkg.sv ***
// types for the disk controller status and error register bank
package dsr_pkg;

	typedef struct packed {
		logic busy;
		logic ready;
		logic write_fault;
		logic seek_done;
		logic transfer_request;
		logic fixed_data;
		logic index_pulse;
		logic command_error;
	} dsr_status_type;

	typedef struct packed {
		logic bad_block;
		logic unfixable_data;
		logic sector_id_missing;
		logic command_rejected;
		logic home_track_missing;
	} dsr_error_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dsr_apb_out_type;

	typedef struct packed {
		logic [7:0] q1;
		logic [7:0] q2;
	} dsr_sync_state_type;

	typedef struct packed {
		dsr_status_type status;
		dsr_error_type error;
		dsr_apb_out_type apb;
	} dsr_state_type;

endpackage

// *** verilog/dsr_sync.sv ***
// two-stage synchroniser for a byte of drive status levels
`timescale 1ns/1ps
`include "dsr_defs.svh"
module dsr_sync
	import dsr_pkg::*;
(
	// clock and reset
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	// levels
	input wire logic [7:0] d_in,
	output logic [7:0] q_out
);
	dsr_sync_state_type r;
	dsr_sync_state_type next_r;

	// first stage feeds only the second
	always_comb begin
		next_r = r;
		next_r.q1 = d_in;
		next_r.q2 = r.q1;
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_out = r.q2;
endmodule // dsr_sync

// *** verif/dsr_regs_asserts.sv ***
// checker for the status and error register bank
`timescale 1ns/1ps
module dsr_regs_chk (
	// watched ports
	input wire logic CLK_IN, RST_N_IN, PSEL_IN, PENABLE_IN, PREADY_OUT, CMD_DONE_IN,
	input wire logic DRIVE_READY_IN, WRITE_FAULT_IN, SEEK_DONE_IN, TRANSFER_REQUEST_IN,
	input wire logic FIXED_DATA_EV_IN, UNFIXABLE_DATA_EV_IN, SECTOR_ID_MISSING_EV_IN,
	input wire logic COMMAND_REJECTED_EV_IN, HOME_TRACK_MISSING_EV_IN, BAD_BLOCK_EV_IN,
	input wire logic [31:0] PRDATA_OUT,
	input wire logic [7:0] STATUS_OUT, ERROR_OUT
);
	// ------
	// helpers
	// ------
	// pin checks wait out the synchroniser after each reset
	logic [1:0] up;
	wire logic any_err = UNFIXABLE_DATA_EV_IN | SECTOR_ID_MISSING_EV_IN |
		COMMAND_REJECTED_EV_IN | HOME_TRACK_MISSING_EV_IN | BAD_BLOCK_EV_IN;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) up <= 2'h0;
		else if (up != 2'h3) up <= up + 2'h1;
	end
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence s_setup;
		PSEL_IN && !PENABLE_IN;
	endsequence
	// ------
	// properties
	// ------
	a_read_answer: assert property (s_setup |=> PREADY_OUT && PRDATA_OUT[31:8] == 24'h0)
		else $error("no answer after setup");
	a_ready_pin: assert property (up == 2'h3 |-> STATUS_OUT[6] == $past(DRIVE_READY_IN, 3))
		else $error("ready bit wrong");
	a_fault_pin: assert property (up == 2'h3 |-> STATUS_OUT[5] == $past(WRITE_FAULT_IN, 3))
		else $error("fault bit wrong");
	a_seek_pin: assert property (up == 2'h3 |-> STATUS_OUT[4] == $past(SEEK_DONE_IN, 3))
		else $error("seek bit wrong");
	a_xfer_pin: assert property (up == 2'h3 |-> STATUS_OUT[3] == $past(TRANSFER_REQUEST_IN, 3))
		else $error("transfer bit wrong");
	a_fixed_load: assert property (CMD_DONE_IN |=> STATUS_OUT[2] == $past(FIXED_DATA_EV_IN))
		else $error("fixed bit wrong");
	a_cmd_error: assert property (CMD_DONE_IN |=> STATUS_OUT[0] == $past(any_err))
		else $error("command error bit wrong");
	a_unfix_id: assert property (CMD_DONE_IN |=> ERROR_OUT[6] == $past(UNFIXABLE_DATA_EV_IN)
		&& ERROR_OUT[4] == $past(SECTOR_ID_MISSING_EV_IN)) else $error("error bits 6 4 wrong");
	a_reject_home: assert property (CMD_DONE_IN |=> ERROR_OUT[2] == $past(COMMAND_REJECTED_EV_IN)
		&& ERROR_OUT[1] == $past(HOME_TRACK_MISSING_EV_IN)) else $error("error bits 2 1 wrong");
	a_unused_zero: assert property ({ERROR_OUT[5], ERROR_OUT[3], ERROR_OUT[0]} == 3'h0)
		else $error("unused error bit set");
endmodule // dsr_regs_chk
bind dsr_regs dsr_regs_chk chk (
	.CLK_IN(CLK_IN),
	.RST_N_IN(RST_N_IN),
	.PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN),
	.PREADY_OUT(PREADY_OUT),
	.CMD_DONE_IN(CMD_DONE_IN),
	.DRIVE_READY_IN(DRIVE_READY_IN),
	.WRITE_FAULT_IN(WRITE_FAULT_IN),
	.SEEK_DONE_IN(SEEK_DONE_IN),
	.TRANSFER_REQUEST_IN(TRANSFER_REQUEST_IN),
	.FIXED_DATA_EV_IN(FIXED_DATA_EV_IN),
	.UNFIXABLE_DATA_EV_IN(UNFIXABLE_DATA_EV_IN),
	.SECTOR_ID_MISSING_EV_IN(SECTOR_ID_MISSING_EV_IN),
	.COMMAND_REJECTED_EV_IN(COMMAND_REJECTED_EV_IN),
	.HOME_TRACK_MISSING_EV_IN(HOME_TRACK_MISSING_EV_IN),
	.BAD_BLOCK_EV_IN(BAD_BLOCK_EV_IN),
	.PRDATA_OUT(PRDATA_OUT),
	.STATUS_OUT(STATUS_OUT),
	.ERROR_OUT(ERROR_OUT)
);

// *** verif/dsr_host.sv ***
// host processor model driving the apb side
`timescale 1ns/1ps
module dsr_host (
	// clock
	input wire logic CLK_IN,
	// apb master
	output logic PSEL_OUT, PENABLE_OUT, PWRITE_OUT,
	output logic [11:0] PADDR_OUT,
	output logic [31:0] PWDATA_OUT,
	input wire logic [31:0] PRDATA_IN,
	input wire logic PREADY_IN, PSLVERR_IN
);
	initial begin
		{PSEL_OUT, PENABLE_OUT, PWRITE_OUT, PADDR_OUT, PWDATA_OUT} = 47'h0;
	end
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge CLK_IN);
		PSEL_OUT <= 1'b1;
		PWRITE_OUT <= w;
		PADDR_OUT <= a;
		PWDATA_OUT <= d;
		@(posedge CLK_IN);
		PENABLE_OUT <= 1'b1;
		// ready, read data and error are all taken at one rising edge
		do @(posedge CLK_IN); while (PREADY_IN !== 1'b1);
		q = PRDATA_IN;
		e = PSLVERR_IN;
		PSEL_OUT <= 1'b0;
		PENABLE_OUT <= 1'b0;
		// released lines must not keep looking valid
		PADDR_OUT <= ~PADDR_OUT;
		PWDATA_OUT <= ~PWDATA_OUT;
	endtask
endmodule // dsr_host

// *** verif/tb_top.sv ***
// testbench for the status and error register bank
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
	logic clk, rst_n, cmd_done, e;
	logic [5:0] pins, ev, x;
	logic [31:0] q;
	int mismatches, cmp_count;
	wire logic psel, penable, pwrite, pready, pslverr;
	wire logic [11:0] paddr;
	wire logic [31:0] pwdata, prdata;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	dsr_host host (.CLK_IN(clk), .PSEL_OUT(psel), .PENABLE_OUT(penable), .PWRITE_OUT(pwrite),
		.PADDR_OUT(paddr), .PWDATA_OUT(pwdata), .PRDATA_IN(prdata), .PREADY_IN(pready),
		.PSLVERR_IN(pslverr));
	dsr_regs uut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
		.PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DRIVE_BUSY_IN(pins[5]),
		.DRIVE_READY_IN(pins[4]), .WRITE_FAULT_IN(pins[3]), .SEEK_DONE_IN(pins[2]),
		.TRANSFER_REQUEST_IN(pins[1]), .INDEX_PULSE_IN(pins[0]), .CMD_DONE_IN(cmd_done),
		.FIXED_DATA_EV_IN(ev[0]), .UNFIXABLE_DATA_EV_IN(ev[1]), .SECTOR_ID_MISSING_EV_IN(ev[2]),
		.COMMAND_REJECTED_EV_IN(ev[3]), .HOME_TRACK_MISSING_EV_IN(ev[4]),
		.BAD_BLOCK_EV_IN(ev[5]), .STATUS_OUT(), .ERROR_OUT());
	task rd(input logic [11:0] a);
		host.xfer(1'b0, a, 32'h0, q, e);
	endtask
	task pulse(input logic [5:0] v);
		@(posedge clk);
		ev <= v;
		cmd_done <= 1'b1;
		@(posedge clk);
		ev <= 6'h00;
		cmd_done <= 1'b0;
	endtask
	task close_out;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		close_out;
	end
	initial begin
		{rst_n, cmd_done, pins, ev, mismatches, cmp_count} = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(12'h000); `CHK(q, 32'h0)
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			pins <= 6'h01 << i;
			repeat (4) @(posedge clk);
			rd(12'h000); `CHK(q, {24'h0, pins[5:1], 1'b0, pins[0], 1'b0})
		end
		@(posedge clk);
		pins <= 6'h00;
		// each pulse reloads the sticky bits, the last one with nothing
		for (int i = 0; i < 7; i++) begin
			x = (i < 6) ? 6'h01 << i : 6'h00;
			pulse(x);
			rd(12'h000); `CHK(q, {24'h0, 5'h00, x[0], 1'b0, |x[5:1]})
			rd(12'h004); `CHK(q, {24'h0, x[5], x[1], 1'b0, x[2], 1'b0, x[3], x[4], 1'b0})
		end
		pulse(6'h3E);
		host.xfer(1'b1, 12'h004, 32'hFF, q, e);
		rd(12'h004); `CHK(q, 32'hD6)
		host.xfer(1'b1, 12'h000, 32'h0, q, e);
		rd(12'h000); `CHK(q, 32'h01)
		host.xfer(1'b1, 12'h008, 32'h1, q, e);
		rd(12'h004); `CHK(q, 32'h0)
		rd(12'h00C); `CHK({e, q}, 33'h1_0000_0000)
		// a reset in mid-run must wipe the sticky command picture
		pulse(6'h3E);
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		rd(12'h004); `CHK(q, 32'h0)
		rd(12'h000); `CHK(q, 32'h0)
		close_out;
	end
endmodule // tb_top
